//--- dmac_pkg.sv
package dmac_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  localparam logic [7:0] DEC_STAT_OFS = 8'h10;

  // ------------------------------------------------------------
  // Control word fields
  // ------------------------------------------------------------
  localparam int IRQ_EN_BIT = 31;
  localparam int DST_INC_BIT = 27;
  localparam int SRC_INC_BIT = 26;
  localparam int DST_WIDTH_LSB = 21;
  localparam int SRC_WIDTH_LSB = 18;
  localparam int DST_BURST_LSB = 15;
  localparam int SRC_BURST_LSB = 12;
  localparam int XFER_COUNT_LSB = 0;
  localparam int XFER_COUNT_W = 12;
  // Bits 30-28 and 25-24 are not stored and read as zero.
  localparam logic [31:0] CTRL_KEEP_MASK = 32'h8cff_ffff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // Configuration, interrupt and decode status fields
  // ------------------------------------------------------------
  localparam int CFG_TC_MASK_BIT = 0;
  localparam logic CFG_TC_MASK_RESET = 1'b0;
  localparam int EV_XFER_END = 0;
  localparam int EV_BAD_WIDTH = 1;
  localparam int EV_NUM = 2;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam int DEC_SRC_STEP_LSB = 0;
  localparam int DEC_DST_STEP_LSB = 4;
  localparam int DEC_SRC_BEATS_LSB = 8;
  localparam int DEC_DST_BEATS_LSB = 17;
  localparam int DEC_SRC_BAD_BIT = 28;
  localparam int DEC_DST_BAD_BIT = 29;

  // ------------------------------------------------------------
  // Bus answers
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Field decoding
  // ------------------------------------------------------------
  // Bytes per beat; reserved codes give zero.
  function automatic logic [2:0] width_bytes(input logic [2:0] code);
    case (code)
      3'h0: width_bytes = 3'h1;
      3'h1: width_bytes = 3'h2;
      3'h2: width_bytes = 3'h4;
      default: width_bytes = 3'h0;
    endcase
  endfunction : width_bytes

  function automatic logic [8:0] burst_beats(input logic [2:0] code);
    case (code)
      3'h0: burst_beats = 9'h001;
      3'h1: burst_beats = 9'h004;
      3'h2: burst_beats = 9'h008;
      3'h3: burst_beats = 9'h010;
      3'h4: burst_beats = 9'h020;
      3'h5: burst_beats = 9'h040;
      3'h6: burst_beats = 9'h080;
      default: burst_beats = 9'h100;
    endcase
  endfunction : burst_beats

endpackage : dmac_pkg

//--- dmac_field_dec.sv
// Registered decode of one side (source or destination) of the
// control word into what the transfer engine consumes.
module dmac_field_dec (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw fields
  input wire logic [2:0] width_code,
  input wire logic [2:0] burst_code,
  input wire logic addr_advance,
  // Decoded values
  output logic [2:0] step_q,
  output logic [2:0] width_bytes_q,
  output logic [8:0] beats_q,
  output logic width_bad_q
);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire logic [2:0] bytes_w = dmac_pkg::width_bytes(width_code);
  wire logic [2:0] step_w = addr_advance ? bytes_w : 3'h0;
  wire logic bad_w = (bytes_w == 3'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_q <= 3'h0;
      width_bytes_q <= 3'h1;
      beats_q <= 9'h001;
      width_bad_q <= 1'b0;
    end else begin
      step_q <= step_w;
      width_bytes_q <= bytes_w;
      beats_q <= dmac_pkg::burst_beats(burst_code);
      width_bad_q <= bad_w;
    end
  end

endmodule : dmac_field_dec

//--- dmac_irq.sv
// Sticky event flags with write-one-to-clear, a mask and one level
// interrupt line.
module dmac_irq #(
  parameter int N = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events and software access
  input wire logic [N-1:0] event_set,
  input wire logic [N-1:0] clear_w1c,
  input wire logic mask_we,
  input wire logic [N-1:0] mask_wdata,
  // State
  output logic [N-1:0] status_q,
  output logic [N-1:0] mask_q,
  output logic irq_q
);

  // A set arriving with its own clear is kept, so no event is lost.
  wire logic [N-1:0] status_d = (status_q & ~clear_w1c) | event_set;
  wire logic [N-1:0] mask_d = mask_we ? mask_wdata : mask_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= |(status_d & mask_d);
    end
  end

endmodule : dmac_irq

//--- dmac_ctrl.sv
// Register access over AXI4-Lite and the placing of the registers were decided locally.
module dmac_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Transfer engine side
  input wire logic xfer_end,
  input wire logic lli_load,
  input wire logic [31:0] lli_ctrl,
  // Decoded fields for the engine
  output logic irq_enable,
  output logic [2:0] src_step,
  output logic [2:0] dst_step,
  output logic [2:0] src_width_bytes,
  output logic [2:0] dst_width_bytes,
  output logic [8:0] src_burst_len,
  output logic [8:0] dest_burst_len,
  output logic [11:0] xfer_count,
  // Interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic tc_mask_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic irq_en_q;
  logic [11:0] xfer_count_q;
  logic [dmac_pkg::EV_NUM-1:0] irq_status;
  logic [dmac_pkg::EV_NUM-1:0] irq_mask;
  logic irq_w;
  logic [2:0] src_step_w;
  logic [2:0] dst_step_w;
  logic [2:0] src_bytes_w;
  logic [2:0] dst_bytes_w;
  logic [8:0] src_beats_w;
  logic [8:0] dst_beats_w;
  logic src_bad_w;
  logic dst_bad_w;

  // ------------------------------------------------------------
  // Write channel handshake
  // ------------------------------------------------------------
  // Address and data are taken independently; the write happens
  // once both are held, and the response follows one cycle later.
  wire logic aw_fire = awvalid & awready_q;
  wire logic w_fire = wvalid & wready_q;
  wire logic wr_do = aw_hold_q & w_hold_q;
  wire logic aw_hold_d = (aw_hold_q | aw_fire) & ~wr_do;
  wire logic w_hold_d = (w_hold_q | w_fire) & ~wr_do;
  wire logic bvalid_d = wr_do | (bvalid_q & ~bready);
  wire logic awready_d = ~aw_hold_d & ~bvalid_d & ~wr_do;
  wire logic wready_d = ~w_hold_d & ~bvalid_d & ~wr_do;
  wire logic [7:0] awaddr_d = aw_fire ? awaddr : awaddr_q;
  wire logic [31:0] wdata_d = w_fire ? wdata : wdata_q;
  wire logic [3:0] wstrb_d = w_fire ? wstrb : wstrb_q;

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  // A write to an unmapped offset is answered with an error but still
  // completes, so the master never waits on it.
  // Byte strobes act lane by lane on the control word; configuration needs lane 0 and the other registers ignore them.
  wire logic wr_ctrl = wr_do & (awaddr_q == dmac_pkg::CTRL_OFS);
  wire logic wr_cfg = wr_do & (awaddr_q == dmac_pkg::CFG_OFS);
  wire logic wr_stat = wr_do & (awaddr_q == dmac_pkg::IRQ_STAT_OFS);
  wire logic wr_mask = wr_do & (awaddr_q == dmac_pkg::IRQ_MASK_OFS);
  wire logic wr_dec = wr_do & (awaddr_q == dmac_pkg::DEC_STAT_OFS);
  wire logic wr_hit = wr_ctrl | wr_cfg | wr_stat | wr_mask | wr_dec;
  wire logic [1:0] bresp_d = wr_do ?
    (wr_hit ? dmac_pkg::RESP_OKAY : dmac_pkg::RESP_SLVERR) : bresp_q;

  wire logic [31:0] byte_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                                 {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire logic [31:0] wr_merged = (ctrl_q & ~byte_mask)
                                | (wdata_q & byte_mask);

  // ------------------------------------------------------------
  // Control word
  // ------------------------------------------------------------
  // A linked item load wins over a software write in the same
  // cycle: while the chain runs the word belongs to the engine.
  // Reserved bits are dropped so a stray one cannot steer anything.
  wire logic [31:0] ctrl_src = lli_load ? lli_ctrl : wr_merged;
  wire logic ctrl_we = lli_load | wr_ctrl;
  wire logic [31:0] ctrl_d = ctrl_we ?
    (ctrl_src & dmac_pkg::CTRL_KEEP_MASK) : ctrl_q;

  // Configuration holds the terminal-count mask.
  wire logic tc_mask_d = (wr_cfg & wstrb_q[0]) ?
    wdata_q[dmac_pkg::CFG_TC_MASK_BIT] : tc_mask_q;

  // ------------------------------------------------------------
  // Field extraction
  // ------------------------------------------------------------
  // Fields other than the count and the interrupt enable come from the stored word, so the decoders lag it by one
  // edge; the engine must not start a beat in that cycle.
  wire logic dst_inc = ctrl_q[dmac_pkg::DST_INC_BIT];
  wire logic src_inc = ctrl_q[dmac_pkg::SRC_INC_BIT];
  wire logic [2:0] dst_width = ctrl_q[dmac_pkg::DST_WIDTH_LSB +: 3];
  wire logic [2:0] src_width = ctrl_q[dmac_pkg::SRC_WIDTH_LSB +: 3];
  wire logic [2:0] dst_burst = ctrl_q[dmac_pkg::DST_BURST_LSB +: 3];
  wire logic [2:0] src_burst = ctrl_q[dmac_pkg::SRC_BURST_LSB +: 3];
  wire logic [11:0] count_d =
    ctrl_d[dmac_pkg::XFER_COUNT_LSB +: dmac_pkg::XFER_COUNT_W];

  // ------------------------------------------------------------
  // Field decoders
  // ------------------------------------------------------------
  // Alignment of start addresses is software's duty; the step
  // sizes here assume it has been kept.
  dmac_field_dec u_src_dec (
    .aclk (aclk),
    .aresetn (aresetn),
    .width_code (src_width),
    .burst_code (src_burst),
    .addr_advance (src_inc),
    .step_q (src_step_w),
    .width_bytes_q (src_bytes_w),
    .beats_q (src_beats_w),
    .width_bad_q (src_bad_w)
  );

  dmac_field_dec u_dst_dec (
    .aclk (aclk),
    .aresetn (aresetn),
    .width_code (dst_width),
    .burst_code (dst_burst),
    .addr_advance (dst_inc),
    .step_q (dst_step_w),
    .width_bytes_q (dst_bytes_w),
    .beats_q (dst_beats_w),
    .width_bad_q (dst_bad_w)
  );

  // ------------------------------------------------------------
  // Events and interrupt
  // ------------------------------------------------------------
  // The transfer-end event needs both enables; either one low
  // swallows the end of transfer without a trace.
  wire logic ev_xfer_end = xfer_end & ctrl_q[dmac_pkg::IRQ_EN_BIT]
                           & tc_mask_q;
  // A reserved width code is flagged in the cycle it appears, and not again while it stays.
  logic bad_seen_q;
  wire logic bad_now = src_bad_w | dst_bad_w;
  wire logic ev_bad_width = bad_now & ~bad_seen_q;

  wire logic [dmac_pkg::EV_NUM-1:0] ev_set = {ev_bad_width, ev_xfer_end};
  wire logic [dmac_pkg::EV_NUM-1:0] ev_clear =
    wr_stat ? wdata_q[dmac_pkg::EV_NUM-1:0] : '0;

  dmac_irq #(
    .N (dmac_pkg::EV_NUM)
  ) u_irq (
    .aclk (aclk),
    .aresetn (aresetn),
    .event_set (ev_set),
    .clear_w1c (ev_clear),
    .mask_we (wr_mask),
    .mask_wdata (wdata_q[dmac_pkg::EV_NUM-1:0]),
    .status_q (irq_status),
    .mask_q (irq_mask),
    .irq_q (irq_w)
  );

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  // Only one read is in flight: arready falls as the address is taken
  // and rises the cycle after the data are accepted, so the read mux
  // looks at the live address only on the taking edge.
  wire logic ar_fire = arvalid & arready_q;
  wire logic rvalid_d = ar_fire | (rvalid_q & ~rready);
  wire logic arready_d = ~rvalid_d;

  // The decode word shows software the steps and beats the engine is given,
  // and flags a reserved width that has been flattened to zero.
  wire logic [31:0] dec_word =
    (32'(src_step_w) << dmac_pkg::DEC_SRC_STEP_LSB)
    | (32'(dst_step_w) << dmac_pkg::DEC_DST_STEP_LSB)
    | (32'(src_beats_w) << dmac_pkg::DEC_SRC_BEATS_LSB)
    | (32'(dst_beats_w) << dmac_pkg::DEC_DST_BEATS_LSB)
    | (32'(src_bad_w) << dmac_pkg::DEC_SRC_BAD_BIT)
    | (32'(dst_bad_w) << dmac_pkg::DEC_DST_BAD_BIT);

  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (araddr)
      dmac_pkg::CTRL_OFS: rd_word = ctrl_q;
      dmac_pkg::CFG_OFS:
        rd_word = 32'(tc_mask_q) << dmac_pkg::CFG_TC_MASK_BIT;
      dmac_pkg::IRQ_STAT_OFS: rd_word = 32'(irq_status);
      dmac_pkg::IRQ_MASK_OFS: rd_word = 32'(irq_mask);
      dmac_pkg::DEC_STAT_OFS: rd_word = dec_word;
      default: rd_hit = 1'b0;
    endcase
  end

  wire logic [31:0] rdata_d = ar_fire ? rd_word : rdata_q;
  wire logic [1:0] rresp_d = ar_fire ?
    (rd_hit ? dmac_pkg::RESP_OKAY : dmac_pkg::RESP_SLVERR) : rresp_q;

  // ------------------------------------------------------------
  // Bus state
  // ------------------------------------------------------------
  // Handshake flags and payload registers are kept apart so that the
  // reset list of each stays short and easy to audit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= dmac_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      rresp_q <= dmac_pkg::RESP_OKAY;
    end else begin
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ------------------------------------------------------------
  // Channel state
  // ------------------------------------------------------------
  // The interrupt enable copies the next control value, so it changes
  // on the same edge as the stored word itself.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= dmac_pkg::CTRL_RESET;
      tc_mask_q <= dmac_pkg::CFG_TC_MASK_RESET;
      bad_seen_q <= 1'b0;
      irq_en_q <= 1'b0;
      xfer_count_q <= 12'h000;
    end else begin
      ctrl_q <= ctrl_d;
      tc_mask_q <= tc_mask_d;
      bad_seen_q <= bad_now;
      irq_en_q <= ctrl_d[dmac_pkg::IRQ_EN_BIT];
      xfer_count_q <= count_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every output below is a register here or in a submodule; no logic
  // sits between a flop and a pin.
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq_enable = irq_en_q;
  assign src_step = src_step_w;
  assign dst_step = dst_step_w;
  assign src_width_bytes = src_bytes_w;
  assign dst_width_bytes = dst_bytes_w;
  assign src_burst_len = src_beats_w;
  assign dest_burst_len = dst_beats_w;
  assign xfer_count = xfer_count_q;
  assign irq = irq_w;

endmodule : dmac_ctrl

//--- dcf_monitor.sv
module dcf_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Observed ports
  input wire logic lli_load,
  input wire logic [31:0] lli_ctrl,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic irq,
  input wire logic irq_enable,
  input wire logic [2:0] src_step,
  input wire logic [2:0] dst_step,
  input wire logic [2:0] src_width_bytes,
  input wire logic [2:0] dst_width_bytes,
  input wire logic [8:0] src_burst_len,
  input wire logic [8:0] dest_burst_len
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // Field decoding
  // ------------------------------------------------------------
  // Reserved width codes give zero so a stray code cannot pass.
  function automatic logic [2:0] wb(input logic [2:0] c);
    return (c > 3'h2) ? 3'h0 : 3'h1 << c;
  endfunction : wb

  function automatic logic [8:0] bb(input logic [2:0] c);
    return 9'h001 << ((c == 3'h0) ? 4'h0 : {1'b0, c} + 4'h1);
  endfunction : bb

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Decoded outputs settle one edge after the word lands, so two edges.
  dst_dec_a: assert property (lli_load |-> ##2 (
    dst_width_bytes == wb($past(lli_ctrl[23:21], 2)) &&
    dest_burst_len == bb($past(lli_ctrl[17:15], 2)) &&
    dst_step == ($past(lli_ctrl[27], 2) ? dst_width_bytes : 3'h0)))
    else $error("destination decode wrong after item load");
  src_dec_a: assert property (lli_load |-> ##2 (
    src_width_bytes == wb($past(lli_ctrl[20:18], 2)) &&
    src_burst_len == bb($past(lli_ctrl[14:12], 2)) &&
    src_step == ($past(lli_ctrl[26], 2) ? src_width_bytes : 3'h0)))
    else $error("source decode wrong after item load");
  dst_step_a: assert property (
    dst_step == 3'h0 || dst_step == dst_width_bytes)
    else $error("destination step differs from its width");
  src_step_a: assert property (
    src_step == 3'h0 || src_step == src_width_bytes)
    else $error("source step differs from its width");
  irq_en_a: assert property (
    lli_load ##1 !lli_load |=> irq_enable == $past(lli_ctrl[31], 2))
    else $error("interrupt enable not taken from item word");
  bresp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before handshake");
  rdata_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before handshake");
  rst_val_a: assert property (disable iff (1'b0)
    !aresetn |=> !irq && !bvalid && !rvalid && src_burst_len == 9'h001)
    else $error("outputs not at reset values");

  cover property ($rose(irq));
  cover property (lli_load);
  cover property (bvalid && bready && bresp == 2'h2);
  cover property (bvalid && !bready);
endmodule : dcf_monitor

//--- dma_channel_control_fields_tb.sv
module dma_channel_control_fields_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic xfer_end, lli_load, awready, wready, bvalid, arready, rvalid;
  logic irq_enable, irq, hold_rsp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, lli_ctrl, rd;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] src_step, dst_step, src_width_bytes, dst_width_bytes;
  logic [8:0] src_burst_len, dest_burst_len;
  logic [11:0] xfer_count;
  int n_fail;
  int n_checks;
  typedef struct packed {
    logic [31:0] c;
    logic [2:0] dw, ds;
    logic [8:0] db;
    logic [2:0] sw, ss;
    logic [8:0] sb;
  } dcf_row_s;
  // Word, then dst width/step/beats, then src width/step/beats.
  // Steps are byte counts that assume software aligned the start.
  dcf_row_s rows [8] = '{
    '{32'h0000_0000, 3'h1, 3'h0, 9'h001, 3'h1, 3'h0, 9'h001},
    '{32'h0c44_f000, 3'h4, 3'h4, 9'h004, 3'h2, 3'h2, 9'h100},
    '{32'h0829_3000, 3'h2, 3'h2, 9'h008, 3'h4, 3'h0, 9'h010},
    '{32'h0401_c000, 3'h1, 3'h0, 9'h010, 3'h1, 3'h1, 9'h020},
    '{32'h0c7e_5000, 3'h0, 3'h0, 9'h020, 3'h0, 3'h0, 9'h040},
    '{32'h7302_efff, 3'h1, 3'h0, 9'h040, 3'h1, 3'h0, 9'h080},
    '{32'h0003_1000, 3'h1, 3'h0, 9'h080, 3'h1, 3'h0, 9'h004},
    '{32'h8003_a000, 3'h1, 3'h0, 9'h100, 3'h1, 3'h0, 9'h008}};

  dmac_ctrl i_dmac_ctrl (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
    .rdata, .rresp, .xfer_end, .lli_load, .lli_ctrl, .irq_enable,
    .src_step, .dst_step, .src_width_bytes, .dst_width_bytes,
    .src_burst_len, .dest_burst_len, .xfer_count, .irq);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // Bench tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo(input int k);
    if (k >= 40) begin
      n_fail++;
      end_sim();
    end
  endtask : tmo

  // Both tasks are entered just after a rising edge. With hold_rsp set
  // the master keeps its ready low until the answer is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !hold_rsp;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
    rs = bresp;
    @(posedge aclk);
    tmo(k);
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !hold_rsp;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    @(posedge aclk);
    tmo(k);
  endtask : rd_reg

  // One-cycle pulse of either an item load or a transfer end.
  task automatic pulse(input logic [31:0] w, input logic ld);
    lli_ctrl <= w;
    lli_load <= ld;
    xfer_end <= !ld;
    @(posedge aclk);
    lli_load <= 1'b0;
    xfer_end <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {xfer_end, lli_load, awaddr, araddr, wdata, lli_ctrl} = '0;
    n_fail = 0;
    hold_rsp = 1'b0;
    n_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(src_burst_len, 9'h001);
    chk(dst_width_bytes, 3'h1);
    chk(irq, 1'b0);
    rd_reg(dmac_pkg::CTRL_OFS);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      wr(dmac_pkg::CTRL_OFS, rows[i].c);
      repeat (3) @(posedge aclk);
      chk(dst_width_bytes, rows[i].dw);
      chk(dst_step, rows[i].ds);
      chk(dest_burst_len, rows[i].db);
      chk(src_width_bytes, rows[i].sw);
      chk(src_step, rows[i].ss);
      chk(src_burst_len, rows[i].sb);
      chk(irq_enable, rows[i].c[31]);
      chk(xfer_count, rows[i].c[11:0]);
      rd_reg(dmac_pkg::CTRL_OFS);
      chk(rd, rows[i].c & dmac_pkg::CTRL_KEEP_MASK);
    end
    // Unmapped places and the read-only decode word.
    rd_reg(8'h14);
    chk(rs, dmac_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    chk(rs, dmac_pkg::RESP_SLVERR);
    wr(dmac_pkg::DEC_STAT_OFS, 32'h0);
    rd_reg(dmac_pkg::DEC_STAT_OFS);
    chk(rd, 32'h0200_0800);
    // Interrupt needs both the word enable and the config mask.
    wr(dmac_pkg::IRQ_STAT_OFS, 32'h3);
    wr(dmac_pkg::IRQ_MASK_OFS, 32'h1);
    for (int j = 1; j < 4; j++) begin
      wr(dmac_pkg::CFG_OFS, {31'h0, j[0]});
      wr(dmac_pkg::CTRL_OFS, {j[1], 31'h0});
      pulse(32'h0, 1'b0);
      chk(irq, j == 3);
      rd_reg(dmac_pkg::IRQ_STAT_OFS);
      chk(rd, {31'h0, j == 3});
    end
    wr(dmac_pkg::IRQ_MASK_OFS, 32'h0);
    rd_reg(dmac_pkg::IRQ_STAT_OFS);
    chk(irq, 1'b0);
    wr(dmac_pkg::IRQ_MASK_OFS, 32'h1);
    rd_reg(dmac_pkg::IRQ_STAT_OFS);
    chk(irq, 1'b1);
    wr(dmac_pkg::IRQ_STAT_OFS, 32'h1);
    rd_reg(dmac_pkg::IRQ_STAT_OFS);
    chk(irq, 1'b0);
    chk(rd, 32'h0);
    // Linked items choose their own interrupt.
    pulse(32'h0c44_f000, 1'b1);
    pulse(32'h0, 1'b0);
    chk(irq, 1'b0);
    pulse(32'h8829_3000, 1'b1);
    pulse(32'h0, 1'b0);
    chk(irq, 1'b1);
    // Reset in mid-run, then answers held back by the master.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(irq, 1'b0);
    chk(irq_enable, 1'b0);
    chk(dest_burst_len, 9'h001);
    chk(xfer_count, 12'h000);
    hold_rsp = 1'b1;
    wr(dmac_pkg::CTRL_OFS, 32'h0c44_f000);
    chk(rs, dmac_pkg::RESP_OKAY);
    rd_reg(dmac_pkg::CFG_OFS);
    chk(rd, 32'h0);
    chk(rs, dmac_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(dst_step, 3'h4);
    end_sim();
  end
endmodule : dma_channel_control_fields_tb

bind dmac_ctrl dcf_monitor i_dcf_monitor (
  .aclk, .aresetn, .lli_load, .lli_ctrl, .bvalid, .bready, .bresp,
  .rvalid, .rready, .rdata, .irq, .irq_enable, .src_step, .dst_step,
  .src_width_bytes, .dst_width_bytes, .src_burst_len, .dest_burst_len);
